// file: rtl/csb_cfg.svh
// offsets, field positions and reset values of the core status bank
`ifndef CSB_CFG_SVH
`define CSB_CFG_SVH

// ====================================================================
// register indices (byte address on the bus is four times the index)
`define CSB_IDX_INDIRECT_PORT 8'h80
`define CSB_IDX_OPTION_CONTROL 8'h81
`define CSB_IDX_PC_LOW 8'h82
`define CSB_IDX_ARITH_RESET_FLAGS 8'h83
`define CSB_IDX_INDIRECT_POINTER 8'h84
`define CSB_IDX_PORT_A_DIRECTION 8'h85
`define CSB_IDX_PORT_B_DIRECTION 8'h86
`define CSB_IDX_PC_HIGH_LATCH 8'h8A
`define CSB_IDX_INTERRUPT_CONTROL 8'h8B
`define CSB_IDX_PERIPH_INT_ENABLE 8'h8C
`define CSB_IDX_RESET_CAUSE_FLAGS 8'h8E
`define CSB_IDX_EEPROM_SERIAL_IF 8'h90
`define CSB_IDX_VREF_CONTROL 8'h9F
// bank-0 mirror of the status register as a data-memory address
`define CSB_STATUS_MIRROR_ADDR 9'h003
// upper index bits shared by every bank-1 entry
`define CSB_BANK1_TAG 3'b100

// ====================================================================
// status register fields
`define CSB_ST_CARRY 0
`define CSB_ST_NIBBLE 1
`define CSB_ST_ZERO 2
`define CSB_ST_SLEEP 3
`define CSB_ST_WDT 4
`define CSB_ST_BANK_LOW 5
`define CSB_ST_BANK_HIGH 6
`define CSB_ST_INDIRECT_BANK 7
// reset-cause fields
`define CSB_RC_POWER_ON 1
`define CSB_RC_BROWN_OUT 0

// ====================================================================
// reset values and writable masks
`define CSB_RST_STATUS_POR 8'h18
`define CSB_RST_OPTION 8'hFF
`define CSB_RST_PORT_A_DIR 8'h1F
`define CSB_RST_PORT_B_DIR 8'hFF
`define CSB_RST_EEPROM_IF 8'h07
`define CSB_RST_ZERO 8'h00
`define CSB_MASK_FULL 8'hFF
`define CSB_MASK_PORT_A_DIR 8'h1F
`define CSB_MASK_PC_HIGH 8'h1F
`define CSB_MASK_PERIPH_INT 8'h40
`define CSB_MASK_RESET_CAUSE 8'h03
`define CSB_MASK_EEPROM_IF 8'h07
`define CSB_MASK_VREF 8'hEF

// ====================================================================
// bus answer codes
`define CSB_RESP_OKAY 2'b00
`define CSB_AXI_ADDR_W 10

`endif

// file: rtl/csb_pkg.sv
// types shared by the core status bank
package csb_pkg;
    // ================================================================
    // flag-affecting operation reported by the instruction datapath
    typedef enum logic [2:0] {
        CSB_ALU_ADD,
        CSB_ALU_SUB,
        CSB_ALU_LOGIC,
        CSB_ALU_ROT_LEFT,
        CSB_ALU_ROT_RIGHT
    } csb_alu_op_t;
endpackage

// file: rtl/csb_core_status_sfr_bank.sv
// core special-function register bank with arithmetic and reset status
// What this block does
// - status register is a normal write destination
// - flag-affecting instruction blocks data write to flags
// - watchdog and sleep flags ignore writes
// - status reachable at 03h and 83h
// - bank-select bits pick the 128-byte bank
// - watchdog flag set by power-up, kick, sleep
// - sleep flag set by power-up, kick; sleep clears
// - zero flag follows result equal zero
// - nibble flag is carry from bit three
// - carry from top bit, subtraction adds complement
// - rotates load carry with shifted-out bit
// - unimplemented locations and bits read zero
// - power-on and other resets differ
`timescale 1ns/1ns
`include "csb_cfg.svh"

module csb_core_status_sfr_bank
    import csb_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // reset cause, valid while aresetn is low
    input wire logic rst_cause_power_on,
    input wire logic rst_cause_brown_out,
    input wire logic rst_cause_watchdog,
    // watchdog and sleep events from the datapath
    input wire logic watchdog_kick_instr,
    input wire logic sleep_instr,
    input wire logic wdt_timeout,
    // datapath register access
    input wire logic [6:0] cpu_addr,
    input wire logic cpu_indirect,
    input wire logic cpu_wr,
    input wire logic [7:0] cpu_wdata,
    output logic [8:0] cpu_eff_addr,
    output logic [7:0] cpu_rdata,
    // datapath flag update
    input wire logic alu_valid,
    input wire csb_alu_op_t alu_op,
    input wire logic [7:0] alu_a,
    input wire logic [7:0] alu_b,
    // register contents toward the core
    output logic [7:0] arith_reset_flags,
    output logic [7:0] indirect_pointer,
    output logic [7:0] option_control,
    output logic [7:0] program_counter_high_latch,
    output logic [7:0] reset_cause_flags,
    // axi4-lite write address and data
    input wire logic [`CSB_AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [`CSB_AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ================================================================
    // storage
    logic [7:0] sfr [32];
    logic [7:0] status;
    logic [`CSB_AXI_ADDR_W-1:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane;

    // writable bits per entry; zero marks an unimplemented location or the status entry
    function automatic logic [7:0] wmask(input logic [4:0] i);
        unique case ({`CSB_BANK1_TAG, i})
            `CSB_IDX_OPTION_CONTROL: wmask = `CSB_MASK_FULL;
            `CSB_IDX_PC_LOW: wmask = `CSB_MASK_FULL;
            `CSB_IDX_INDIRECT_POINTER: wmask = `CSB_MASK_FULL;
            `CSB_IDX_PORT_A_DIRECTION: wmask = `CSB_MASK_PORT_A_DIR;
            `CSB_IDX_PORT_B_DIRECTION: wmask = `CSB_MASK_FULL;
            `CSB_IDX_PC_HIGH_LATCH: wmask = `CSB_MASK_PC_HIGH;
            `CSB_IDX_INTERRUPT_CONTROL: wmask = `CSB_MASK_FULL;
            `CSB_IDX_PERIPH_INT_ENABLE: wmask = `CSB_MASK_PERIPH_INT;
            `CSB_IDX_RESET_CAUSE_FLAGS: wmask = `CSB_MASK_RESET_CAUSE;
            `CSB_IDX_EEPROM_SERIAL_IF: wmask = `CSB_MASK_EEPROM_IF;
            `CSB_IDX_VREF_CONTROL: wmask = `CSB_MASK_VREF;
            default: wmask = `CSB_RST_ZERO;
        endcase
    endfunction

    function automatic logic [7:0] rst_val(input logic [4:0] i);
        unique case ({`CSB_BANK1_TAG, i})
            `CSB_IDX_OPTION_CONTROL: rst_val = `CSB_RST_OPTION;
            `CSB_IDX_PORT_A_DIRECTION: rst_val = `CSB_RST_PORT_A_DIR;
            `CSB_IDX_PORT_B_DIRECTION: rst_val = `CSB_RST_PORT_B_DIR;
            `CSB_IDX_EEPROM_SERIAL_IF: rst_val = `CSB_RST_EEPROM_IF;
            default: rst_val = `CSB_RST_ZERO;
        endcase
    endfunction

    function automatic logic [7:0] rd_val(input logic [4:0] i);
        if ({`CSB_BANK1_TAG, i} == `CSB_IDX_ARITH_RESET_FLAGS) begin
            rd_val = status;
        end else begin
            rd_val = sfr[i] & wmask(i);
        end
    endfunction

    // ================================================================
    // address decode and write arbitration
    logic [8:0] eff;
    logic cpu_hit;
    logic [4:0] axi_rd_idx;
    logic axi_rd_hit;
    logic do_axi_write;
    logic wr_en;
    logic [4:0] wr_idx;
    logic [7:0] wr_data;
    logic wr_status;
    logic [8:0] add_sum;
    logic [4:0] add_nib;

    always_comb begin
        if (cpu_indirect) begin
            eff = {status[`CSB_ST_INDIRECT_BANK], indirect_pointer};
        end else begin
            eff = {status[`CSB_ST_BANK_HIGH:`CSB_ST_BANK_LOW], cpu_addr};
        end
    end

    // bank-1 window and bank-0 status mirror
    assign cpu_hit = (eff[8:5] == {1'b0, `CSB_BANK1_TAG}) ||
                     (eff == `CSB_STATUS_MIRROR_ADDR);
    assign axi_rd_idx = s_axi_araddr[6:2];
    assign axi_rd_hit = (s_axi_araddr[9:7] == `CSB_BANK1_TAG);
    // a bus write waits while the datapath writes
    assign do_axi_write = !s_axi_awready && !s_axi_wready &&
                          !s_axi_bvalid && !cpu_wr;

    always_comb begin
        wr_en = 1'b0;
        wr_idx = eff[4:0];
        wr_data = cpu_wdata;
        if (cpu_wr && cpu_hit) begin
            wr_en = 1'b1;
        end else if (do_axi_write) begin
            wr_en = (aw_addr[9:7] == `CSB_BANK1_TAG) && w_lane;
            wr_idx = aw_addr[6:2];
            wr_data = w_byte;
        end
    end
    assign wr_status = wr_en &&
        ({`CSB_BANK1_TAG, wr_idx} == `CSB_IDX_ARITH_RESET_FLAGS);

    // ================================================================
    // plain registers, with power-on and other reset values
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 32; i++) begin
                if (rst_cause_power_on) begin
                    sfr[i] <= rst_val(5'(i));
                end else if ({`CSB_BANK1_TAG, 5'(i)} ==
                             `CSB_IDX_INTERRUPT_CONTROL) begin
                    sfr[i] <= {7'h00, sfr[i][0]};
                end else if ({`CSB_BANK1_TAG, 5'(i)} ==
                             `CSB_IDX_RESET_CAUSE_FLAGS) begin
                    sfr[i][7:2] <= 6'h00;
                    sfr[i][`CSB_RC_BROWN_OUT] <= rst_cause_brown_out ?
                        1'b0 : sfr[i][`CSB_RC_BROWN_OUT];
                end else if ({`CSB_BANK1_TAG, 5'(i)} !=
                             `CSB_IDX_INDIRECT_POINTER) begin
                    sfr[i] <= rst_val(5'(i));
                end
            end
        end else if (wr_en && !wr_status) begin
            sfr[wr_idx] <= (sfr[wr_idx] & ~wmask(wr_idx)) |
                           (wr_data & wmask(wr_idx));
        end
    end

    // ================================================================
    // arithmetic and reset status
    assign add_sum = (alu_op == CSB_ALU_SUB) ?
        {1'b0, alu_a} + {1'b0, ~alu_b} + 9'h001 :
        {1'b0, alu_a} + {1'b0, alu_b};
    assign add_nib = (alu_op == CSB_ALU_SUB) ?
        {1'b0, alu_a[3:0]} + {1'b0, ~alu_b[3:0]} + 5'h01 :
        {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            if (rst_cause_power_on) begin
                status <= `CSB_RST_STATUS_POR;
            end else begin
                status[7:5] <= 3'b000;
                if (rst_cause_watchdog) begin
                    status[`CSB_ST_WDT] <= 1'b0;
                end
            end
        end else begin
            if (wr_status) begin
                // bank bits are software's; reserved ones kept clear by it
                status[7:5] <= wr_data[7:5];
                if (!(cpu_wr && alu_valid)) begin
                    status[2:0] <= wr_data[2:0];
                end
            end
            // sleep and watchdog flags take no data write
            if (watchdog_kick_instr || sleep_instr) begin
                status[`CSB_ST_WDT] <= 1'b1;
            end else if (wdt_timeout) begin
                status[`CSB_ST_WDT] <= 1'b0;
            end
            if (watchdog_kick_instr) begin
                status[`CSB_ST_SLEEP] <= 1'b1;
            end else if (sleep_instr) begin
                status[`CSB_ST_SLEEP] <= 1'b0;
            end
            if (alu_valid) begin
                unique case (alu_op)
                    CSB_ALU_ADD, CSB_ALU_SUB: begin
                        status[`CSB_ST_ZERO] <= add_sum[7:0] == 8'h00;
                        status[`CSB_ST_NIBBLE] <= add_nib[4];
                        status[`CSB_ST_CARRY] <= add_sum[8];
                    end
                    CSB_ALU_LOGIC: begin
                        status[`CSB_ST_ZERO] <= alu_a == 8'h00;
                    end
                    CSB_ALU_ROT_LEFT: begin
                        status[`CSB_ST_CARRY] <= alu_a[7];
                    end
                    CSB_ALU_ROT_RIGHT: begin
                        status[`CSB_ST_CARRY] <= alu_a[0];
                    end
                endcase
            end
        end
    end

    // ================================================================
    // datapath read and effective address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_eff_addr <= 9'h000;
            cpu_rdata <= 8'h00;
        end else begin
            cpu_eff_addr <= eff;
            cpu_rdata <= cpu_hit ? rd_val(eff[4:0]) : 8'h00;
        end
    end

    assign arith_reset_flags = status;
    assign indirect_pointer = sfr[5'(`CSB_IDX_INDIRECT_POINTER)];
    assign option_control = sfr[5'(`CSB_IDX_OPTION_CONTROL)];
    assign program_counter_high_latch = sfr[5'(`CSB_IDX_PC_HIGH_LATCH)];
    assign reset_cause_flags = sfr[5'(`CSB_IDX_RESET_CAUSE_FLAGS)];

    // ================================================================
    // axi4-lite write channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            aw_addr <= '0;
        end else if (s_axi_awready && s_axi_awvalid) begin
            s_axi_awready <= 1'b0;
            aw_addr <= s_axi_awaddr;
        end else if (do_axi_write) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b1;
            w_byte <= 8'h00;
            w_lane <= 1'b0;
        end else if (s_axi_wready && s_axi_wvalid) begin
            s_axi_wready <= 1'b0;
            w_byte <= s_axi_wdata[7:0];
            w_lane <= s_axi_wstrb[0];
        end else if (do_axi_write) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
        end else if (do_axi_write) begin
            s_axi_bvalid <= 1'b1;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
    assign s_axi_bresp = `CSB_RESP_OKAY;

    // ================================================================
    // axi4-lite read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
        end else if (s_axi_arready && s_axi_arvalid) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, axi_rd_hit ?
                rd_val(axi_rd_idx) : 8'h00};
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
    assign s_axi_rresp = `CSB_RESP_OKAY;

    // ================================================================
    // checks
    logic [8:0] chk_sum;
    logic [4:0] chk_nib;
    assign chk_sum = 9'(alu_a) + 9'(alu_b);
    assign chk_nib = 5'(alu_a[3:0]) + 5'(alu_b[3:0]);

    sequence s_mirror_write;
        cpu_wr && !cpu_indirect && !alu_valid &&
        status[6:5] == 2'b00 && cpu_addr == 7'h03;
    endsequence
    sequence s_unimpl_read;
        s_axi_arvalid && s_axi_arready &&
        s_axi_araddr == 10'(4 * 9'h087);
    endsequence

    AST_STATUS_MIRROR: assert property (@(posedge aclk) disable iff (!aresetn)
        s_mirror_write |=> status[7:5] == $past(cpu_wdata[7:5]))
        else $error("status mirror write lost");
    AST_WIPE_SETS_ZERO: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (cpu_wr && wr_status && alu_valid && alu_op == CSB_ALU_LOGIC &&
         alu_a == 8'h00 && cpu_wdata == 8'h00)
        |=> status[`CSB_ST_ZERO] &&
            status[1:0] == $past(status[1:0]))
        else $error("flag write not suppressed");
    AST_TO_PD_READ_ONLY: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (wr_status && !watchdog_kick_instr && !sleep_instr && !wdt_timeout)
        |=> $stable(status[4:3]))
        else $error("watchdog or sleep flag written");
    AST_KICK_SETS_FLAGS: assert property (@(posedge aclk)
        disable iff (!aresetn)
        watchdog_kick_instr |=> status[4:3] == 2'b11)
        else $error("kick did not set flags");
    AST_SLEEP_CLEARS_PD: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (sleep_instr && !watchdog_kick_instr) |=>
        !status[`CSB_ST_SLEEP] && status[`CSB_ST_WDT])
        else $error("sleep flags wrong");
    AST_ZERO_FLAG: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (alu_valid && alu_op == CSB_ALU_ADD) |=>
        status[`CSB_ST_ZERO] == ($past(chk_sum[7:0]) == 8'h00))
        else $error("zero flag wrong");
    AST_ADD_CARRIES: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (alu_valid && alu_op == CSB_ALU_ADD) |=>
        status[1:0] == {$past(chk_nib[4]), $past(chk_sum[8])})
        else $error("add carries wrong");
    AST_ROTATE_CARRY: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (alu_valid && alu_op == CSB_ALU_ROT_RIGHT) |=>
        status[`CSB_ST_CARRY] == $past(alu_a[0]))
        else $error("rotate carry wrong");
    AST_UNIMPL_READ_ZERO: assert property (@(posedge aclk)
        disable iff (!aresetn)
        s_unimpl_read |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0000)
        else $error("unimplemented read not zero");
    AST_POR_VALUE: assert property (@(posedge aclk)
        (!aresetn && rst_cause_power_on) |=>
        status == `CSB_RST_STATUS_POR && option_control == `CSB_RST_OPTION)
        else $error("power-on reset value wrong");
    AST_BANK_ADDR: assert property (@(posedge aclk)
        disable iff (!aresetn)
        !cpu_indirect |=> cpu_eff_addr ==
        {$past(status[6:5]), $past(cpu_addr)})
        else $error("bank select wrong");

endmodule // csb_core_status_sfr_bank

// file: tb/csb_cpu_model.sv
// behavioural instruction datapath and watchdog source facing the bank
`timescale 1ns/1ns

module csb_cpu_model
    import csb_pkg::*;
(
    // clock
    input wire logic aclk,
    // watchdog and sleep events
    output logic watchdog_kick_instr,
    output logic sleep_instr,
    output logic wdt_timeout,
    // register access and flag update
    output logic [6:0] cpu_addr,
    output logic cpu_indirect,
    output logic cpu_wr,
    output logic [7:0] cpu_wdata,
    output logic alu_valid,
    output csb_alu_op_t alu_op,
    output logic [7:0] alu_a,
    output logic [7:0] alu_b
);
    initial begin
        {watchdog_kick_instr, sleep_instr, wdt_timeout} = 3'b000;
        {cpu_addr, cpu_indirect, cpu_wr, cpu_wdata} = 17'h0_0000;
        {alu_valid, alu_a, alu_b} = 17'h0_0000;
        alu_op = CSB_ALU_ADD;
    end

    // ================================================================
    // one instruction cycle; released operands show their inverse
    task automatic step(input logic [6:0] a, input logic ind,
        input logic wr, input logic [7:0] d, input logic av,
        input csb_alu_op_t op, input logic [7:0] x, input logic [7:0] y);
        @(posedge aclk);
        cpu_addr <= a;
        cpu_indirect <= ind;
        cpu_wr <= wr;
        cpu_wdata <= d;
        alu_valid <= av;
        alu_op <= op;
        alu_a <= x;
        alu_b <= y;
        @(posedge aclk);
        cpu_wr <= 1'b0;
        alu_valid <= 1'b0;
        cpu_addr <= ~a;
        cpu_wdata <= ~d;
        alu_a <= ~x;
        alu_b <= ~y;
    endtask

    // one-cycle kick, sleep and time-out pulses
    task automatic ev(input logic k, input logic s, input logic t);
        @(posedge aclk);
        {watchdog_kick_instr, sleep_instr, wdt_timeout} <= {k, s, t};
        @(posedge aclk);
        {watchdog_kick_instr, sleep_instr, wdt_timeout} <= 3'b000;
    endtask
endmodule // csb_cpu_model

// file: tb/test_core_status_sfr_bank.sv
// self-checking bench for the core status register bank
`timescale 1ns/1ns
`include "csb_cfg.svh"
`define CHK(a, e) begin \
    checks_done++; \
    if ((a) !== (e)) begin \
        error_cnt++; \
        $display("ERROR %0t got %h expected %h", $time, a, e); \
    end \
end

module test_core_status_sfr_bank
    import csb_pkg::*;
;
    // ================================================================
    // signals and tables
    logic aclk, aresetn, cause_po, cause_bo, cause_wd;
    logic kick, slp, wto, ind, cwr, av;
    logic [6:0] caddr;
    logic [7:0] cwd, aa, ab, c_rdata, st, d, a, b;
    csb_alu_op_t aop, op;
    logic [8:0] eff;
    logic [7:0] o_st, o_ip, o_opt, o_pch, o_rc;
    logic [`CSB_AXI_ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata, e;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] exp_q[$];
    logic [7:0] cur [15];
    int error_cnt = 0;
    int checks_done = 0;
    localparam logic [7:0] ridx [15] = '{8'h80, 8'h81, 8'h82, 8'h83,
        8'h84, 8'h85, 8'h86, 8'h87, 8'h8A, 8'h8B, 8'h8C, 8'h8E, 8'h90,
        8'h9E, 8'h9F};
    localparam logic [7:0] por [15] = '{8'h00, 8'hFF, 8'h00, 8'h18,
        8'h00, 8'h1F, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h07,
        8'h00, 8'h00};
    localparam logic [7:0] wmask [15] = '{8'h00, 8'hFF, 8'hFF, 8'h27,
        8'hFF, 8'h1F, 8'hFF, 8'h00, 8'h1F, 8'hFF, 8'h40, 8'h03, 8'h07,
        8'h00, 8'hEF};

    csb_core_status_sfr_bank u_csb_core_status_sfr_bank (
        .aclk(aclk), .aresetn(aresetn),
        .rst_cause_power_on(cause_po), .rst_cause_brown_out(cause_bo),
        .rst_cause_watchdog(cause_wd),
        .watchdog_kick_instr(kick), .sleep_instr(slp), .wdt_timeout(wto),
        .cpu_addr(caddr), .cpu_indirect(ind), .cpu_wr(cwr),
        .cpu_wdata(cwd), .cpu_eff_addr(eff), .cpu_rdata(c_rdata),
        .alu_valid(av), .alu_op(aop), .alu_a(aa), .alu_b(ab),
        .arith_reset_flags(o_st), .indirect_pointer(o_ip),
        .option_control(o_opt), .program_counter_high_latch(o_pch),
        .reset_cause_flags(o_rc),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    csb_cpu_model u_csb_cpu_model (
        .aclk(aclk), .watchdog_kick_instr(kick), .sleep_instr(slp),
        .wdt_timeout(wto), .cpu_addr(caddr), .cpu_indirect(ind),
        .cpu_wr(cwr), .cpu_wdata(cwd), .alu_valid(av), .alu_op(aop),
        .alu_a(aa), .alu_b(ab));

    // ================================================================
    // clock, verdict, watchdog, read monitor
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic close_out();
        if (error_cnt == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        close_out();
    end

    always @(posedge aclk) begin
        if (rvalid && rready) begin
            e = exp_q.pop_front();
            `CHK(rdata, e)
            `CHK(rresp, `CSB_RESP_OKAY)
        end
    end

    // ================================================================
    // bus tasks and flag model
    task automatic axi_wr(input logic [7:0] i, input logic [7:0] v,
        input logic [3:0] s);
        bit done = 0;
        logic [23:0] hi = 24'($urandom);
        @(posedge aclk);
        awaddr <= {i, 2'b00};
        wdata <= {hi, v};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                done = 1;
                `CHK(bresp, `CSB_RESP_OKAY)
            end
        end
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] i, input logic [7:0] v);
        bit done = 0;
        exp_q.push_back({24'h00_0000, v});
        @(posedge aclk);
        araddr <= {i, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) done = 1;
        end
        rready <= 1'b0;
    endtask

    task automatic do_reset(input logic p, input logic bo, input logic w);
        @(posedge aclk);
        aresetn <= 1'b0;
        cause_po <= p;
        cause_bo <= bo;
        cause_wd <= w;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
    endtask

    function automatic logic [7:0] flags(csb_alu_op_t o, logic [7:0] x,
        logic [7:0] y, logic [7:0] s);
        logic [8:0] r = {1'b0, x} + {1'b0, y};
        logic [4:0] h = {1'b0, x[3:0]} + {1'b0, y[3:0]};
        if (o == CSB_ALU_SUB) begin
            r = {1'b0, x} + {1'b0, ~y} + 9'h001;
            h = {1'b0, x[3:0]} + {1'b0, ~y[3:0]} + 5'h01;
        end
        if (o == CSB_ALU_ADD || o == CSB_ALU_SUB)
            s[2:0] = {r[7:0] == 8'h00, h[4], r[8]};
        else if (o == CSB_ALU_LOGIC)
            s[2] = (x == 8'h00);
        else
            s[0] = (o == CSB_ALU_ROT_LEFT) ? x[7] : x[0];
        return s;
    endfunction

    // ================================================================
    // main sequence
    initial begin
        {aresetn, cause_bo, cause_wd, cause_po} = 4'h1;
        {awaddr, araddr, wdata, wstrb} = 56'h00_0000_0000_0000;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        void'($urandom(75));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (ridx[i]) axi_rd(ridx[i], por[i]);
        for (int i = 0; i < 15; i++) begin
            d = 8'($urandom);
            if (ridx[i] == 8'h83) d = d & 8'h27;
            cur[i] = (d & wmask[i]) | ((ridx[i] == 8'h83) ? 8'h18 : 8'h00);
            axi_wr(ridx[i], d, 4'h1);
        end
        foreach (ridx[i]) axi_rd(ridx[i], cur[i]);
        axi_wr(8'h84, ~cur[4], 4'h0);
        axi_rd(8'h84, cur[4]);
        axi_wr(8'h83, 8'h00, 4'h1);
        u_csb_cpu_model.step(7'h03, 0, 1, 8'h01, 0, CSB_ALU_ADD, 0, 0);
        axi_rd(8'h83, 8'h19);
        axi_wr(8'h83, 8'h27, 4'h1);
        u_csb_cpu_model.step(7'h03, 0, 1, 8'h00, 1, CSB_ALU_LOGIC, 0, 0);
        axi_rd(8'h83, 8'h1F);
        u_csb_cpu_model.ev(0, 0, 1);
        axi_rd(8'h83, 8'h0F);
        u_csb_cpu_model.ev(0, 1, 0);
        axi_rd(8'h83, 8'h17);
        u_csb_cpu_model.ev(1, 0, 1);
        axi_rd(8'h83, 8'h1F);
        st = 8'h1F;
        for (int i = 0; i < 30; i++) begin
            op = csb_alu_op_t'(i % 5);
            a = (i < 5) ? 8'h00 : (i < 10) ? 8'hFF : 8'($urandom);
            b = (i < 5) ? 8'h00 : (i < 10) ? 8'h01 : 8'($urandom);
            u_csb_cpu_model.step(7'($urandom), 0, 0, 8'h00, 1, op, a, b);
            st = flags(op, a, b, st);
            axi_rd(8'h83, st);
        end
        for (int k = 0; k < 4; k++) begin
            axi_wr(8'h83, {1'b0, 2'(k), 5'h00}, 4'h1);
            u_csb_cpu_model.step(7'h05, 0, 0, 8'h00, 0, CSB_ALU_ADD, 0, 0);
            #1 `CHK(eff, {2'(k), 7'h05})
        end
        axi_wr(8'h84, 8'h83, 4'h1);
        axi_wr(8'h83, 8'h20, 4'h1);
        u_csb_cpu_model.step(7'h00, 1, 0, 8'h00, 0, CSB_ALU_ADD, 0, 0);
        #1 `CHK(eff, 9'h083)
        `CHK(c_rdata, 8'h38)
        axi_wr(8'h8B, 8'hFF, 4'h1);
        axi_wr(8'h8E, 8'h03, 4'h1);
        axi_wr(8'h81, 8'h00, 4'h1);
        do_reset(0, 1, 1);
        axi_rd(8'h83, 8'h08);
        axi_rd(8'h84, 8'h83);
        axi_rd(8'h8B, 8'h01);
        axi_rd(8'h8E, 8'h02);
        axi_rd(8'h81, 8'hFF);
        u_csb_cpu_model.ev(1, 0, 0);
        axi_wr(8'h83, 8'h23, 4'h1);
        do_reset(0, 0, 0);
        axi_rd(8'h83, 8'h1B);
        axi_rd(8'h8E, 8'h02);
        `CHK({o_st, o_ip, o_opt, o_pch, o_rc}, 40'h1B_83FF_0002)
        close_out();
    end
endmodule // test_core_status_sfr_bank
